// ==== hw/svic_defines.vh ====
// Register map, field positions and reset values of the interrupt controller
`ifndef SVIC_DEFINES_VH
`define SVIC_DEFINES_VH

// Register offsets on the 8-bit register port
`define SVIC_OFS_ENABLE_A 8'h0b
`define SVIC_OFS_PENDING_A 8'h0c
`define SVIC_OFS_ENABLE_B 8'h0d
`define SVIC_OFS_PENDING_B 8'h0e
`define SVIC_OFS_OPTION_EDGE 8'h81
`define SVIC_OFS_OPTION_PIN 8'h91

// Bit positions in enable/pending register pair A
`define SVIC_A_ADC 7
`define SVIC_A_SECOND_TIMER 6
`define SVIC_A_TIMER_ONE 5
`define SVIC_A_TIMER_ZERO 4
`define SVIC_A_WAKEUP_TIMER 3
`define SVIC_A_EXT_TWO 2
`define SVIC_A_EXT_ONE 1
`define SVIC_A_EXT_ZERO 0

// Bit positions in enable/pending register pair B
`define SVIC_B_COMPARATOR 4
`define SVIC_B_PWM 1
`define SVIC_B_LOW_VOLTAGE 0
`define SVIC_B_USED_MASK 8'h13

// Edge/prescale option register fields
`define SVIC_OPT_EXT_ZERO_EDGE 6
`define SVIC_OPT_EXT_ONE_EDGE 5
`define SVIC_OPT_EDGE_MASK 8'hef

// Pin select option register fields
`define SVIC_OPT_EXT_TWO_PIN 2
`define SVIC_OPT_EXT_ONE_PIN 1
`define SVIC_OPT_EXT_ZERO_PIN 0
`define SVIC_OPT_PIN_MASK 8'h37

// Reset values
`define SVIC_RST_ENABLE 8'h00
`define SVIC_RST_PENDING 8'h00
`define SVIC_RST_OPTION_EDGE 8'h0f
`define SVIC_RST_OPTION_PIN 8'h00

// Vector inserted as a long call target
`define SVIC_VECTOR_ADDR 12'h004

`endif

// ==== hw/svic_top.v ====
// Single-vector interrupt controller with register port and core handshake
//
// Function
// - Eleven sources, one level, one vector
// - Events set pending regardless of enable
// - Request only when pending and enabled
// - Accept at instruction end, call 004
// - In-service clears after instruction past return
// - Requests are level sensitive until cleared
// - Writing zero clears a pending flag
// - Register A bit order: ADC..external zero
// - Wakeup enable bit also runs wakeup timer
// - ADC flag set on conversion complete
// - Timer flags set on overflow
// - Wakeup flag set on timeout
// - External two: falling edge only
// - External zero/one edge select bits
// - Register B: comparator, PWM, low voltage
// - Comparator, PWM, low-voltage events set flags
// - Pin select bits for external inputs
// - All enables, flags, selects reset zero
// - Idle and stop mode wake sources
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/100ps
`include "svic_defines.vh"

module svic_top #(
  parameter ADDR_W = 8
) (
  input wire ref_clk,
  input wire rst_n,
  // Register port
  input wire [ADDR_W-1:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // Peripheral event pulses
  input wire adc_done,
  input wire second_timer_ovf,
  input wire timer_one_ovf,
  input wire timer_zero_ovf,
  input wire wakeup_timer_timeout,
  input wire comparator_trigger,
  input wire pwm_rollover,
  input wire low_voltage_detect,
  // Candidate pins for the external inputs
  input wire pin_pa3,
  input wire pin_pb2,
  input wire pin_pa1,
  input wire pin_pb1,
  input wire pin_pa7,
  input wire pin_pb5,
  // Processor core handshake
  input wire instr_end,
  input wire return_from_interrupt,
  output wire irq_req,
  output reg long_call,
  output wire [11:0] vector_addr,
  output reg in_service,
  // Power management and option register outputs
  input wire idle_mode,
  input wire stop_mode,
  input wire pin_change,
  output reg wake_req,
  output wire wakeup_timer_run,
  output wire [7:0] option_edge_prescale_q,
  output wire [7:0] option_pin_select_q
);

  // Software visible state
  reg [7:0] irq_enable_a; // Enable bits, pair A
  reg [7:0] irq_pending_a; // Pending flags, pair A
  reg [7:0] irq_enable_b; // Enable bits, pair B
  reg [7:0] irq_pending_b; // Pending flags, pair B
  reg [7:0] option_edge_prescale; // Edge select and prescalers
  reg [7:0] option_pin_select; // Pin select and PWM clock

  // Return tracking
  reg ret_seen; // Return instruction has executed

  // External input edge logic
  reg [2:0] ext_prev; // Previous selected pin level
  reg ext_primed; // Previous level holds a real sample
  wire [2:0] ext_level; // Selected pin level per input
  wire [2:0] ext_rise_sel; // One selects rising edge
  wire [2:0] ext_event; // Edge detected per input

  // Decoded write strobes
  wire wr_en_a;
  wire wr_pend_a;
  wire wr_en_b;
  wire wr_pend_b;
  wire wr_opt_edge;
  wire wr_opt_pin;

  // Event vectors laid out in register order
  wire [7:0] evt_a;
  wire [7:0] evt_b;
  wire [7:0] clr_a;
  wire [7:0] clr_b;
  wire [7:0] next_pending_a;
  wire [7:0] next_pending_b;

  // Request terms
  wire [7:0] active_a;
  wire [7:0] active_b;
  wire any_active;
  wire take_irq;
  wire ret_done;
  wire next_wake;

  // Address decode for the register port
  // Full compare: an unmapped write touches nothing, and the
  // port never waits, so no error path is needed
  assign wr_en_a = reg_wr && (reg_addr == `SVIC_OFS_ENABLE_A);
  assign wr_pend_a = reg_wr && (reg_addr == `SVIC_OFS_PENDING_A);
  assign wr_en_b = reg_wr && (reg_addr == `SVIC_OFS_ENABLE_B);
  assign wr_pend_b = reg_wr && (reg_addr == `SVIC_OFS_PENDING_B);
  assign wr_opt_edge = reg_wr && (reg_addr == `SVIC_OFS_OPTION_EDGE);
  assign wr_opt_pin = reg_wr && (reg_addr == `SVIC_OFS_OPTION_PIN);

  // Pin muxes; zero picks the first pin of each pair
  assign ext_level[0] = option_pin_select[`SVIC_OPT_EXT_ZERO_PIN] ?
                        pin_pb2 : pin_pa3;
  assign ext_level[1] = option_pin_select[`SVIC_OPT_EXT_ONE_PIN] ?
                        pin_pb1 : pin_pa1;
  assign ext_level[2] = option_pin_select[`SVIC_OPT_EXT_TWO_PIN] ?
                        pin_pb5 : pin_pa7;

  // Edge polarity; input two has no rising option
  assign ext_rise_sel[0] =
    option_edge_prescale[`SVIC_OPT_EXT_ZERO_EDGE];
  assign ext_rise_sel[1] =
    option_edge_prescale[`SVIC_OPT_EXT_ONE_EDGE];
  // No select bit exists for input two; tied to falling
  assign ext_rise_sel[2] = 1'b0;

  // One edge detector per external input
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_ext
      // Falling when select is zero, rising when one
      // Gated until the first real sample after reset
      assign ext_event[gi] = ext_primed &&
        (ext_rise_sel[gi] ? (ext_level[gi] && !ext_prev[gi])
                          : (!ext_level[gi] && ext_prev[gi]));
    end
  endgenerate

  // Previous sample; first cycle after reset is not trusted,
  // otherwise a pin sitting high would fake a rising edge
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      // History not yet valid
      ext_prev <= 3'h0;
      ext_primed <= 1'b0;
    end else begin
      // Track the selected level every cycle
      ext_prev <= ext_level;
      ext_primed <= 1'b1;
    end
  end

  // Hardware events in pair A bit order
  assign evt_a[`SVIC_A_ADC] = adc_done;
  assign evt_a[`SVIC_A_SECOND_TIMER] = second_timer_ovf;
  assign evt_a[`SVIC_A_TIMER_ONE] = timer_one_ovf;
  assign evt_a[`SVIC_A_TIMER_ZERO] = timer_zero_ovf;
  assign evt_a[`SVIC_A_WAKEUP_TIMER] = wakeup_timer_timeout;
  assign evt_a[`SVIC_A_EXT_TWO] = ext_event[2];
  assign evt_a[`SVIC_A_EXT_ONE] = ext_event[1];
  assign evt_a[`SVIC_A_EXT_ZERO] = ext_event[0];

  // Hardware events in pair B bit order; unused bits never set
  assign evt_b = {3'h0, comparator_trigger, 2'h0,
                  pwm_rollover, low_voltage_detect};

  // Zero written to a flag clears it; a one leaves it alone
  assign clr_a = wr_pend_a ? ~reg_wdata : 8'h00;
  assign clr_b = wr_pend_b ? ~reg_wdata : 8'h00;

  // Set beats clear so an event in the clearing cycle survives;
  // enable plays no part in setting a flag
  assign next_pending_a = (irq_pending_a & ~clr_a) | evt_a;
  assign next_pending_b = ((irq_pending_b & ~clr_b) | evt_b) &
                          `SVIC_B_USED_MASK;

  // Pending flag registers
  // Trade-off: an event input held high keeps setting its
  // flag, so sources are expected to give one-cycle pulses
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      irq_pending_a <= `SVIC_RST_PENDING;
      irq_pending_b <= `SVIC_RST_PENDING;
    end else begin
      irq_pending_a <= next_pending_a;
      irq_pending_b <= next_pending_b;
    end
  end

  // Enable and option registers
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      // Selects start at zero; prescale fields at their default
      irq_enable_a <= `SVIC_RST_ENABLE;
      irq_enable_b <= `SVIC_RST_ENABLE;
      option_edge_prescale <= `SVIC_RST_OPTION_EDGE;
      option_pin_select <= `SVIC_RST_OPTION_PIN;
    end else begin
      // Pair A is fully writable
      if (wr_en_a) begin
        irq_enable_a <= reg_wdata;
      end
      // Pair B keeps only its three implemented bits
      if (wr_en_b) begin
        irq_enable_b <= reg_wdata & `SVIC_B_USED_MASK;
      end
      // Bit 4 of the edge register is not implemented
      if (wr_opt_edge) begin
        option_edge_prescale <= reg_wdata & `SVIC_OPT_EDGE_MASK;
      end
      // Pin select and PWM clock fields only
      if (wr_opt_pin) begin
        option_pin_select <= reg_wdata & `SVIC_OPT_PIN_MASK;
      end
    end
  end

  // The wakeup enable bit doubles as the timer run enable
  // Clearing it stops the timer as well as masking it
  assign wakeup_timer_run = irq_enable_a[`SVIC_A_WAKEUP_TIMER];

  // Option fields that belong to other units
  assign option_edge_prescale_q = option_edge_prescale;
  assign option_pin_select_q = option_pin_select;

  // Sources that are both pending and enabled
  assign active_a = irq_pending_a & irq_enable_a;
  assign active_b = irq_pending_b & irq_enable_b;
  // One request line covers all eleven sources
  assign any_active = |{active_a, active_b};

  // Level request, held off while a routine is in service;
  // it stays up until software clears the flag
  assign irq_req = any_active && !in_service;

  // Take only at an instruction boundary
  assign take_irq = instr_end && irq_req;

  // In-service drops at the end of the instruction after return
  assign ret_done = instr_end && ret_seen;

  // Single common vector; the handler finds its source by
  // reading the pending flags
  assign vector_addr = `SVIC_VECTOR_ADDR;

  // In-service flag and long call insertion
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      // No service in progress after reset
      in_service <= 1'b0;
      long_call <= 1'b0;
      ret_seen <= 1'b0;
    end else begin
      // Vector call lasts exactly one cycle
      long_call <= take_irq;
      if (take_irq) begin
        in_service <= 1'b1;
      end else if (ret_done) begin
        // Still gated this cycle, so the next main-program
        // instruction always runs before a new take
        in_service <= 1'b0;
      end
      // Return seen only while in service; cleared once used
      if (return_from_interrupt && in_service) begin
        ret_seen <= 1'b1;
      end else if (ret_done) begin
        ret_seen <= 1'b0;
      end
    end
  end

  // Wake sources per low-power mode
  assign next_wake =
    (idle_mode &&
      (active_a[`SVIC_A_WAKEUP_TIMER] ||
       active_a[`SVIC_A_SECOND_TIMER] ||
       active_a[`SVIC_A_EXT_TWO] ||
       active_a[`SVIC_A_EXT_ONE] ||
       active_a[`SVIC_A_EXT_ZERO])) ||
    (stop_mode &&
      (active_a[`SVIC_A_EXT_TWO] ||
       active_a[`SVIC_A_EXT_ONE] ||
       active_a[`SVIC_A_EXT_ZERO] ||
       pin_change));

  // Registered wake request to the power manager
  // The request lags its condition by one cycle; the power
  // manager has to tolerate that delay
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      wake_req <= 1'b0;
    end else begin
      wake_req <= next_wake;
    end
  end

  // Read data one cycle after the strobe, zero otherwise;
  // unmapped addresses read as zero
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        // Pair A
        `SVIC_OFS_ENABLE_A: begin
          reg_rdata <= irq_enable_a;
        end
        `SVIC_OFS_PENDING_A: begin
          reg_rdata <= irq_pending_a;
        end
        // Pair B
        `SVIC_OFS_ENABLE_B: begin
          reg_rdata <= irq_enable_b;
        end
        `SVIC_OFS_PENDING_B: begin
          reg_rdata <= irq_pending_b;
        end
        // Option registers
        `SVIC_OFS_OPTION_EDGE: begin
          reg_rdata <= option_edge_prescale;
        end
        `SVIC_OFS_OPTION_PIN: begin
          reg_rdata <= option_pin_select;
        end
        default: begin
          reg_rdata <= 8'h00;
        end
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule // svic_top

// ==== test/svic_chk_asserts.sv ====
// Concurrent checks on the interrupt controller ports
`timescale 1ns/100ps
module svic_chk (
  input wire ref_clk,
  input wire rst_n,
  input wire reg_rd,
  input wire reg_wr,
  input wire [7:0] reg_rdata,
  input wire instr_end,
  input wire irq_req,
  input wire long_call,
  input wire [11:0] vector_addr,
  input wire in_service,
  input wire idle_mode,
  input wire stop_mode,
  input wire wake_req
);
  // One clock domain, reset is the only disable
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  chk_take_call: assert property (
    instr_end && irq_req |=> long_call && in_service)
    else $error("no vector call after take");
  chk_vector_fixed: assert property (vector_addr == 12'h004)
    else $error("vector address wrong");
  chk_call_single: assert property (long_call |=> !long_call)
    else $error("vector call longer than one cycle");
  chk_take_cause: assert property (
    $rose(in_service) |-> $past(instr_end) && $past(irq_req))
    else $error("service entered without take");
  chk_busy_gate: assert property (in_service |-> !irq_req)
    else $error("request while in service");
  chk_level_hold: assert property (
    irq_req && !instr_end && !reg_wr |=> irq_req)
    else $error("request dropped without clear");
  chk_clear_edge: assert property (
    $fell(in_service) |-> $past(instr_end))
    else $error("in service cleared off instruction end");
  chk_stay_busy: assert property (
    in_service && !instr_end |=> in_service)
    else $error("in service dropped mid instruction");
  chk_rd_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  chk_wake_quiet: assert property (
    !idle_mode && !stop_mode |=> !wake_req)
    else $error("wake while running");
endmodule // svic_chk

// ==== test/svic_core_model.sv ====
// Behavioural core: instruction ends and a return from the handler
`timescale 1ns/100ps
module svic_core_model (
  input wire ref_clk,
  input wire rst_n,
  input wire [3:0] gap,
  input wire ret_req,
  input wire in_service,
  output reg instr_end,
  output reg return_from_interrupt
);
  reg [3:0] cnt; // Cycles into the current instruction
  reg ret_done; // Return already given in this service
  // Gap of zero halts the core so no take can happen
  always @(posedge ref_clk) begin
    if (!rst_n || gap == 4'h0) begin
      cnt <= 4'h0;
      instr_end <= 1'b0;
      return_from_interrupt <= 1'b0;
      ret_done <= 1'b0;
    end else begin
      cnt <= (cnt == gap) ? 4'h0 : cnt + 4'h1;
      instr_end <= (cnt == gap);
      // Handler returns mid instruction, once per service
      return_from_interrupt <= in_service && ret_req && !ret_done &&
                               cnt == 4'h1;
      ret_done <= in_service && (ret_done || return_from_interrupt);
    end
  end
endmodule // svic_core_model

// ==== test/single_vector_interrupt_controller_test.sv ====
// Self-checking bench for the interrupt controller
`timescale 1ns/100ps
module single_vector_interrupt_controller_test;
  reg ref_clk = 1'b0;
  reg rst_n = 1'b0;
  reg [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, a, m;
  reg reg_wr = 1'b0, reg_rd = 1'b0, ret_req = 1'b0;
  reg [7:0] ev = 8'h00; // Events: adc, t2, t1, t0, wkt, cmp, pwm, lvd
  reg [5:0] pins = 6'h3f; // pb5 pa7 pb1 pa1 pb2 pa3, idle high
  reg [3:0] gap = 4'h0; // Instruction length, zero halts the core
  reg idle_mode = 1'b0, stop_mode = 1'b0, pin_change = 1'b0;
  wire [7:0] reg_rdata;
  wire instr_end, return_from_interrupt, irq_req, long_call, in_service;
  wire wake_req, wakeup_timer_run;
  wire [11:0] vector_addr;
  wire [7:0] opt_edge_q, opt_pin_q;
  integer n_errors = 0, n_compared = 0, cycles = 0, i;
  always #2 ref_clk = ~ref_clk;
  svic_top dut (.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .adc_done(ev[7]), .second_timer_ovf(ev[6]),
    .timer_one_ovf(ev[5]), .timer_zero_ovf(ev[4]),
    .wakeup_timer_timeout(ev[3]), .comparator_trigger(ev[2]),
    .pwm_rollover(ev[1]), .low_voltage_detect(ev[0]), .pin_pa3(pins[0]),
    .pin_pb2(pins[1]), .pin_pa1(pins[2]), .pin_pb1(pins[3]),
    .pin_pa7(pins[4]), .pin_pb5(pins[5]), .instr_end,
    .return_from_interrupt, .irq_req, .long_call, .vector_addr,
    .in_service, .idle_mode, .stop_mode, .pin_change, .wake_req,
    .wakeup_timer_run, .option_edge_prescale_q(opt_edge_q),
    .option_pin_select_q(opt_pin_q));
  svic_core_model core (.ref_clk, .rst_n, .gap, .ret_req, .in_service,
    .instr_end, .return_from_interrupt);
  task final_report;
    if (n_errors == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task cmp8(input string what, input [7:0] exp, input [7:0] got);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task cmp1(input string what, input exp, input got);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask
  // Register port cycles; strobe held for exactly one edge
  task wr(input [7:0] ad, input [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task rd(input [7:0] ad, input [7:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 cmp8($sformatf("reg %h", ad), exp, reg_rdata);
  endtask
  task pulse(input [7:0] p);
    @(posedge ref_clk);
    ev <= p;
    @(posedge ref_clk);
    ev <= 8'h00;
    #1;
  endtask
  // Move one pin, then read and clear the external flags
  task ext(input integer k, input v, input [7:0] exp);
    @(posedge ref_clk);
    pins[k] <= v;
    repeat (2) @(posedge ref_clk);
    rd(8'h0c, exp);
    wr(8'h0c, 8'h00);
  endtask
  // Bounded wait for the vector call (s=1) or end of service (s=0)
  task wait_on(input integer s, input string what);
    integer n;
    n = 0;
    while ((s ? long_call : !in_service) !== 1'b1 && n < 200) begin
      @(posedge ref_clk);
      #1;
      n = n + 1;
    end
    cmp1(what, 1'b1, s ? long_call : !in_service);
  endtask
  // Hang guard, far above the few hundred cycles needed
  always @(posedge ref_clk) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      n_errors = n_errors + 1;
      final_report;
    end
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(8'h0b, 8'h00);
    rd(8'h0c, 8'h00);
    rd(8'h0d, 8'h00);
    rd(8'h0e, 8'h00);
    rd(8'h81, 8'h0f);
    rd(8'h91, 8'h00);
    cmp8("edge opt rst", 8'h0f, opt_edge_q);
    cmp8("pin opt rst", 8'h00, opt_pin_q);
    rd(8'h55, 8'h00);
    pulse(8'hff);
    rd(8'h0c, 8'hf8);
    rd(8'h0e, 8'h13);
    cmp1("irq masked", 1'b0, irq_req);
    wr(8'h0c, 8'hff);
    rd(8'h0c, 8'hf8);
    wr(8'h0c, 8'hef);
    rd(8'h0c, 8'he8);
    wr(8'h0c, 8'h00);
    wr(8'h0e, 8'h00);
    rd(8'h0e, 8'h00);
    // Each of the eight pulsed sources alone against its own enable bit
    for (i = 0; i < 8; i = i + 1) begin
      a = (i >= 3) ? 8'h0b : 8'h0d;
      m = (i == 2) ? 8'h10 : (8'h01 << i);
      wr(a, m);
      cmp1("wkt run", i == 3, wakeup_timer_run);
      cmp1("irq idle", 1'b0, irq_req);
      pulse(8'h01 << i);
      cmp1("irq raised", 1'b1, irq_req);
      wr(a + 8'h01, ~m);
      cmp1("irq cleared", 1'b0, irq_req);
      wr(a, 8'h00);
    end
    ext(0, 1'b0, 8'h01);
    ext(0, 1'b1, 8'h00);
    wr(8'h81, 8'hff);
    rd(8'h81, 8'hef);
    cmp8("edge opt out", 8'hef, opt_edge_q);
    ext(0, 1'b0, 8'h00);
    ext(0, 1'b1, 8'h01);
    ext(2, 1'b0, 8'h00);
    ext(2, 1'b1, 8'h02);
    ext(4, 1'b0, 8'h04);
    ext(4, 1'b1, 8'h00);
    wr(8'h91, 8'hff);
    rd(8'h91, 8'h37);
    cmp8("pin opt out", 8'h37, opt_pin_q);
    ext(0, 1'b0, 8'h00);
    ext(1, 1'b0, 8'h00);
    ext(1, 1'b1, 8'h01);
    ext(3, 1'b0, 8'h00);
    ext(3, 1'b1, 8'h02);
    ext(5, 1'b0, 8'h04);
    // Take, return with flag still set, take again, then clear
    wr(8'h0b, 8'h10);
    pulse(8'h10);
    @(posedge ref_clk);
    gap <= 4'h3;
    ret_req <= 1'b1;
    wait_on(1, "long_call");
    cmp8("vector lo", 8'h04, vector_addr[7:0]);
    cmp8("vector hi", 8'h00, {4'h0, vector_addr[11:8]});
    cmp1("in_service", 1'b1, in_service);
    cmp1("irq busy", 1'b0, irq_req);
    wait_on(0, "service end");
    @(posedge ref_clk);
    ret_req <= 1'b0;
    #1 cmp1("irq level", 1'b1, irq_req);
    wait_on(1, "long_call again");
    wr(8'h0c, 8'h00);
    @(posedge ref_clk);
    ret_req <= 1'b1;
    wait_on(0, "service end");
    repeat (20) @(posedge ref_clk);
    #1 cmp1("in_service", 1'b0, in_service);
    @(posedge ref_clk);
    gap <= 4'h0;
    wr(8'h0b, 8'h08);
    pulse(8'h08);
    @(posedge ref_clk);
    idle_mode <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 cmp1("wake idle", 1'b1, wake_req);
    @(posedge ref_clk);
    idle_mode <= 1'b0;
    stop_mode <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 cmp1("wake stop", 1'b0, wake_req);
    @(posedge ref_clk);
    pin_change <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 cmp1("wake pin", 1'b1, wake_req);
    // Stop mode with pin change low: wake only from an enabled external flag
    @(posedge ref_clk);
    pin_change <= 1'b0;
    wr(8'h0b, 8'h01);
    #1 cmp1("wake stop quiet", 1'b0, wake_req);
    @(posedge ref_clk);
    pins[1] <= 1'b0;
    @(posedge ref_clk);
    pins[1] <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 cmp1("wake ext stop", 1'b1, wake_req);
    rd(8'h0c, 8'h09);
    final_report;
  end
endmodule // single_vector_interrupt_controller_test
bind svic_top svic_chk u_chk (.ref_clk, .rst_n, .reg_rd, .reg_wr, .reg_rdata,
  .instr_end, .irq_req, .long_call, .vector_addr, .in_service, .idle_mode,
  .stop_mode, .wake_req);
